//--- rtl/fsrp_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FSRP_CONSTS_SVH
`define FSRP_CONSTS_SVH

`define FSRP_ADDR_W          8
`define FSRP_DATA_W          32
`define FSRP_OFS_STATUS      8'h00
`define FSRP_OFS_CONFIG      8'h04
`define FSRP_OFS_COMMAND     8'h08
`define FSRP_OFS_RESULT      8'h0C
`define FSRP_RESP_OKAY       2'h0
`define FSRP_RESP_SLVERR     2'h2

`define FSRP_SR_LOCK_BIT     7
`define FSRP_SR_PERR_BIT     6
`define FSRP_SR_EERR_BIT     5
`define FSRP_SR_BP_HI        4
`define FSRP_SR_BP_LO        2
`define FSRP_SR_WEL_BIT      1
`define FSRP_SR_BUSY_BIT     0
`define FSRP_CR_TBPROT_BIT   5
`define FSRP_CR_BPNV_BIT     3

`define FSRP_CMD_CODE_HI     2
`define FSRP_CMD_SR_HI       15
`define FSRP_CMD_SR_LO       8
`define FSRP_CMD_CR_HI       23
`define FSRP_CMD_CR_LO       16
`define FSRP_CMD_SEC_HI      31
`define FSRP_CMD_SEC_LO      24

`define FSRP_BP_NV_RESET     3'h0
`define FSRP_BP_VOL_RESET    3'h7
`define FSRP_BP_ALL          3'h7
`define FSRP_SECTORS         9'h100

`define FSRP_CLK_NS          25
`define FSRP_WRR_BUSY_NS     200
`define FSRP_WRR_CYCLES      4'((`FSRP_WRR_BUSY_NS + `FSRP_CLK_NS - 1) / `FSRP_CLK_NS)

`endif

//--- rtl/fsrp_pkg.sv
// Types shared by the status register block and its bus slave
`include "fsrp_consts.svh"
package fsrp_pkg;

  typedef logic [`FSRP_ADDR_W-1:0] fsrp_addr_t;
  typedef logic [`FSRP_DATA_W-1:0] fsrp_data_t;

  typedef enum logic [2:0] {
    FSRP_CMD_NOP   = 3'b000,
    FSRP_CMD_WRITE_ENABLE_COMMAND  = 3'b001,
    FSRP_CMD_WRITE_DISABLE_COMMAND  = 3'b010,
    FSRP_CMD_WRR   = 3'b011,
    FSRP_CMD_PROG  = 3'b100,
    FSRP_CMD_ERASE = 3'b101
  } fsrp_cmd_e;

  typedef enum logic [1:0] {
    FSRP_BUSY_IDLE = 2'b00,
    FSRP_BUSY_WRR  = 2'b01,
    FSRP_BUSY_PROG = 2'b10,
    FSRP_BUSY_ERAS = 2'b11
  } fsrp_busy_e;

  typedef struct packed {
    logic       aw_have;
    logic       w_have;
    fsrp_addr_t awaddr;
    fsrp_data_t wdata;
    logic [3:0] wstrb;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    fsrp_data_t rdata;
    logic [1:0] rresp;
    logic       wr_en;
  } fsrp_slv_s;

  typedef struct packed {
    logic       wp_meta;
    logic       wp_sync;
    logic       lock;
    logic [2:0] bp_nv;
    logic [2:0] bp_vol;
    logic       cfg_bpnv;
    logic       cfg_tbprot;
    logic       perr;
    logic       eerr;
    logic       write_enable_latch;
    fsrp_busy_e busy;
    logic [3:0] timer;
    logic       op_start;
    logic       op_erase;
    logic [7:0] op_sector;
    logic       refused;
    logic       accepted;
  } fsrp_core_s;

endpackage

//--- rtl/fsrp_reg_if.sv
// Register access carrier between the bus slave and the status register core
`timescale 1ns/1ps
interface fsrp_reg_if;
  import fsrp_pkg::*;
  logic       wr_en;
  fsrp_addr_t wr_addr;
  fsrp_data_t wr_data;
  logic [3:0] wr_strb;
  fsrp_addr_t rd_addr;
  fsrp_data_t rd_data;

  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
  modport core  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface

//--- rtl/fsrp_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register writes and reads
`timescale 1ns/1ps
`include "fsrp_consts.svh"
module fsrp_axil_slave (
  // Clock, reset, enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  // Write address and data
  input  wire fsrp_pkg::fsrp_addr_t awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire fsrp_pkg::fsrp_data_t wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  // Write response
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // Read address and data
  input  wire fsrp_pkg::fsrp_addr_t araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output fsrp_pkg::fsrp_data_t    rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Register side
  fsrp_reg_if.slave               regs
);
  import fsrp_pkg::*;

  fsrp_slv_s st_ff;
  fsrp_slv_s nxt_st;

  // Address decode shared by both directions
  function automatic logic is_mapped(input fsrp_addr_t a);
    is_mapped = (a == `FSRP_OFS_STATUS) || (a == `FSRP_OFS_CONFIG) ||
                (a == `FSRP_OFS_COMMAND) || (a == `FSRP_OFS_RESULT);
  endfunction

  // Handshakes: address and data taken in either order, response after both
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.wr_en = 1'b0;
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr  = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = wdata;
      nxt_st.wstrb  = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (nxt_st.aw_have && nxt_st.w_have && !st_ff.bvalid) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.wr_en   = is_mapped(nxt_st.awaddr);
      nxt_st.bresp   = is_mapped(nxt_st.awaddr) ? `FSRP_RESP_OKAY : `FSRP_RESP_SLVERR;
    end
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_have && !nxt_st.bvalid;
    // Read channel: data sampled at the address edge
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = is_mapped(araddr) ? regs.rd_data : '0;
      nxt_st.rresp  = is_mapped(araddr) ? `FSRP_RESP_OKAY : `FSRP_RESP_SLVERR;
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign awready      = st_ff.awready;
  assign wready       = st_ff.wready;
  assign bvalid       = st_ff.bvalid;
  assign bresp        = st_ff.bresp;
  assign arready      = st_ff.arready;
  assign rvalid       = st_ff.rvalid;
  assign rdata        = st_ff.rdata;
  assign rresp        = st_ff.rresp;
  assign regs.wr_en   = st_ff.wr_en;
  assign regs.wr_addr = st_ff.awaddr;
  assign regs.wr_data = st_ff.wdata;
  assign regs.wr_strb = st_ff.wstrb;
  assign regs.rd_addr = araddr;
endmodule

//--- rtl/fsrp_status_reg.sv
// Flash status register one with write lock, block protection and write gating
//
// Summary of operation
// R01 - Lock set and protect pin low: drop writes
// R02 - Lock clear: register writes never protected
// R03 - Block-protect range refuses program and erase
// R04 - Latch set: accept write, program, erase
// R05 - Latch clear: ignore write, program, erase
// R06 - Only enable/disable commands change the latch
// R07 - Busy reads one while operation runs
// R08 - Busy reads zero when idle
// R09 - Protect bits volatile or nonvolatile per config
// R10 - Error flags volatile, read-only, reset zero
`timescale 1ns/1ps
`include "fsrp_consts.svh"
module fsrp_status_reg (
  // Clock, reset, enable
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite write channels
  input  wire fsrp_pkg::fsrp_addr_t s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire fsrp_pkg::fsrp_data_t s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read channels
  input  wire fsrp_pkg::fsrp_addr_t s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output fsrp_pkg::fsrp_data_t      s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Write-protect pin
  input  wire logic                 write_protect_n,
  // Array engine
  output logic                      op_start,
  output logic                      op_erase,
  output logic [7:0]                op_sector,
  input  wire logic                 op_done,
  input  wire logic                 op_fail,
  // Status view
  output logic [7:0]                status_register_one
);
  import fsrp_pkg::*;

  fsrp_reg_if regs ();
  fsrp_core_s st_ff;
  fsrp_core_s nxt_st;

  fsrp_cmd_e  cmd;
  logic [2:0] bp_cur;
  logic [7:0] sr_view;
  logic [7:0] cr_view;
  logic       cmd_hit;

  // Bus slave
  fsrp_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs)
  );

  // Sector range test; protected span doubles with each step of the code from 1 up
  function automatic logic in_protected(input logic [2:0] bp, input logic bottom, input logic [7:0] sec);
    logic [8:0] span;
    span = 9'h000;
    if (bp == `FSRP_BP_ALL) begin
      span = `FSRP_SECTORS;
    end else if (bp != 3'h0) begin
      span = 9'h001 << (bp + 3'h1);
    end
    if (bottom) begin
      in_protected = {1'b0, sec} < span;
    end else begin
      in_protected = {1'b0, sec} >= (`FSRP_SECTORS - span);
    end
  endfunction

  // Register views and command decode
  always_comb begin
    bp_cur  = st_ff.cfg_bpnv ? st_ff.bp_vol : st_ff.bp_nv; // R09
    sr_view = '0;
    sr_view[`FSRP_SR_LOCK_BIT]           = st_ff.lock;
    sr_view[`FSRP_SR_PERR_BIT]           = st_ff.perr;
    sr_view[`FSRP_SR_EERR_BIT]           = st_ff.eerr;
    sr_view[`FSRP_SR_BP_HI:`FSRP_SR_BP_LO] = bp_cur;
    sr_view[`FSRP_SR_WEL_BIT]            = st_ff.write_enable_latch;
    sr_view[`FSRP_SR_BUSY_BIT]           = (st_ff.busy != FSRP_BUSY_IDLE); // R07 R08
    cr_view = '0;
    cr_view[`FSRP_CR_TBPROT_BIT] = st_ff.cfg_tbprot;
    cr_view[`FSRP_CR_BPNV_BIT]   = st_ff.cfg_bpnv;
    cmd     = fsrp_cmd_e'(regs.wr_data[`FSRP_CMD_CODE_HI:0]);
    cmd_hit = regs.wr_en && (regs.wr_addr == `FSRP_OFS_COMMAND) && regs.wr_strb[0];
  end

  // Read multiplexer for the bus slave
  always_comb begin
    case (regs.rd_addr)
      `FSRP_OFS_STATUS: regs.rd_data = {24'h0000_00, sr_view};
      `FSRP_OFS_CONFIG: regs.rd_data = {24'h0000_00, cr_view};
      `FSRP_OFS_RESULT: regs.rd_data = {30'h0000_0000, st_ff.accepted, st_ff.refused};
      default:          regs.rd_data = 32'h0000_0000;
    endcase
  end

  // Next state: pin sync, busy tracking and command execution
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.op_start = 1'b0;
    nxt_st.wp_meta  = write_protect_n;
    nxt_st.wp_sync  = st_ff.wp_meta;
    case (st_ff.busy)
      FSRP_BUSY_WRR: begin
        nxt_st.timer = st_ff.timer - 4'h1;
        if (st_ff.timer == 4'h1) begin
          nxt_st.busy = FSRP_BUSY_IDLE; // R08
        end
      end
      FSRP_BUSY_PROG: begin
        if (op_done) begin
          nxt_st.busy = FSRP_BUSY_IDLE;
          nxt_st.perr = op_fail; // R10
        end
      end
      FSRP_BUSY_ERAS: begin
        if (op_done) begin
          nxt_st.busy = FSRP_BUSY_IDLE;
          nxt_st.eerr = op_fail; // R10
        end
      end
      default: begin
        nxt_st.timer = 4'h0;
      end
    endcase
    if (cmd_hit) begin
      nxt_st.refused  = 1'b0;
      nxt_st.accepted = 1'b0;
      if (st_ff.busy != FSRP_BUSY_IDLE) begin
        nxt_st.refused = 1'b1; // R07
      end else begin
        case (cmd)
          FSRP_CMD_WRITE_ENABLE_COMMAND: begin
            nxt_st.write_enable_latch      = 1'b1; // R06
            nxt_st.accepted = 1'b1;
          end
          FSRP_CMD_WRITE_DISABLE_COMMAND: begin
            nxt_st.write_enable_latch      = 1'b0; // R06
            nxt_st.accepted = 1'b1;
          end
          FSRP_CMD_WRR: begin
            if (!st_ff.write_enable_latch) begin
              nxt_st.refused = 1'b1; // R05
            end else if (st_ff.lock && !st_ff.wp_sync) begin
              nxt_st.refused = 1'b1; // R01
            end else begin
              // Latch untouched here; lock only matters with pin low
              nxt_st.lock       = regs.wr_data[`FSRP_CMD_SR_LO + `FSRP_SR_LOCK_BIT]; // R02 R04 R06
              nxt_st.cfg_bpnv   = regs.wr_data[`FSRP_CMD_CR_LO + `FSRP_CR_BPNV_BIT];
              nxt_st.cfg_tbprot = regs.wr_data[`FSRP_CMD_CR_LO + `FSRP_CR_TBPROT_BIT];
              if (st_ff.cfg_bpnv) begin
                nxt_st.bp_vol = regs.wr_data[`FSRP_CMD_SR_LO + `FSRP_SR_BP_HI:`FSRP_CMD_SR_LO + `FSRP_SR_BP_LO]; // R09
              end else begin
                nxt_st.bp_nv  = regs.wr_data[`FSRP_CMD_SR_LO + `FSRP_SR_BP_HI:`FSRP_CMD_SR_LO + `FSRP_SR_BP_LO]; // R09
              end
              nxt_st.busy     = FSRP_BUSY_WRR; // R07
              nxt_st.timer    = `FSRP_WRR_CYCLES;
              nxt_st.accepted = 1'b1;
            end
          end
          FSRP_CMD_PROG, FSRP_CMD_ERASE: begin
            if (!st_ff.write_enable_latch) begin
              nxt_st.refused = 1'b1; // R05
            end else if (in_protected(bp_cur, st_ff.cfg_tbprot,
                                      regs.wr_data[`FSRP_CMD_SEC_HI:`FSRP_CMD_SEC_LO])) begin
              nxt_st.refused = 1'b1; // R03
            end else begin
              nxt_st.op_start  = 1'b1; // R04
              nxt_st.op_erase  = (cmd == FSRP_CMD_ERASE);
              nxt_st.op_sector = regs.wr_data[`FSRP_CMD_SEC_HI:`FSRP_CMD_SEC_LO];
              nxt_st.busy      = (cmd == FSRP_CMD_ERASE) ? FSRP_BUSY_ERAS : FSRP_BUSY_PROG; // R07
              nxt_st.accepted  = 1'b1;
              if (cmd == FSRP_CMD_ERASE) begin
                nxt_st.eerr = 1'b0;
              end else begin
                nxt_st.perr = 1'b0;
              end
            end
          end
          default: begin
            nxt_st.refused = 1'b1;
          end
        endcase
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff            <= '0; // R10
      st_ff.bp_nv      <= `FSRP_BP_NV_RESET;
      st_ff.bp_vol     <= `FSRP_BP_VOL_RESET;
      st_ff.wp_meta    <= 1'b1;
      st_ff.wp_sync    <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state
  assign op_start            = st_ff.op_start;
  assign op_erase            = st_ff.op_erase;
  assign op_sector           = st_ff.op_sector;
  assign status_register_one = sr_view;
endmodule

//--- sim/fsrp_engine_model.sv
// Array engine model answering program and erase launches
`timescale 1ns/1ps
module fsrp_engine_model (
  // Clock
  input  wire logic       aclk,
  // Launch from the block and bench controls
  input  wire logic       op_start,
  input  wire logic       fail_req,
  input  wire logic [3:0] delay,
  // Completion back to the block
  output logic            op_done,
  output logic            op_fail
);
  logic [3:0] cnt = 4'h0;
  initial begin
    op_done = 1'b0;
    op_fail = 1'b0;
  end
  // One done pulse per launch; fail toggles away from done so it is never trusted alone
  always @(posedge aclk) begin
    op_done <= (cnt == 4'h1);
    op_fail <= (cnt == 4'h1) ? fail_req : ~op_fail;
    if (op_start) cnt <= delay;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule

//--- sim/fsrp_status_reg_monitor.sv
// Checker for status register one and its launch handshake
`timescale 1ns/1ps
module fsrp_status_reg_monitor (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Observed ports
  input  wire logic       s_axi_bvalid,
  input  wire logic       write_protect_n,
  input  wire logic       op_start,
  input  wire logic       op_erase,
  input  wire logic       op_done,
  input  wire logic       op_fail,
  input  wire logic [7:0] status_register_one
);
  logic [2:0] low_cnt_ff;
  logic [2:0] nxt_low_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturating count of cycles the protect pin has stayed low
  always_comb begin
    nxt_low_cnt = write_protect_n ? 3'h0 : low_cnt_ff + {2'h0, low_cnt_ff != 3'h7};
  end
  always_ff @(posedge aclk) begin
    low_cnt_ff <= aresetn ? nxt_low_cnt : 3'h0;
  end
  // Launch and finish steps of an array operation
  sequence s_launch;
    op_start ##1 !op_start;
  endsequence
  sequence s_finish;
    op_done && status_register_one[0];
  endsequence
  property p_start_wel;   op_start |-> $past(status_register_one[1]); endproperty
  property p_start_busy;  op_start |-> status_register_one[0]; endproperty
  property p_start_pulse; op_start |-> s_launch; endproperty
  property p_done_idle;   s_finish |=> !status_register_one[0]; endproperty
  property p_perr;        s_finish and (op_fail && !op_erase) |=> status_register_one[6]; endproperty
  property p_eerr;        s_finish and (op_fail && op_erase) |=> status_register_one[5]; endproperty
  property p_wel_cause;   $changed(status_register_one[1]) |-> $past(s_axi_bvalid); endproperty
  property p_bp_cause;
    $changed({status_register_one[7], status_register_one[4:2]}) |-> $past(s_axi_bvalid);
  endproperty
  property p_lock;
    (low_cnt_ff >= 3'h4 && status_register_one[7]) |=> $stable({status_register_one[7], status_register_one[4:2]});
  endproperty
  a_start_wel: assert property (p_start_wel) else $error("launch without write enable");
  a_start_busy: assert property (p_start_busy) else $error("launch without busy");
  a_start_pulse: assert property (p_start_pulse) else $error("launch not one cycle");
  a_done_idle: assert property (p_done_idle) else $error("busy after done");
  a_perr: assert property (p_perr) else $error("program error not flagged");
  a_eerr: assert property (p_eerr) else $error("erase error not flagged");
  a_wel_cause: assert property (p_wel_cause) else $error("latch changed without command");
  a_bp_cause: assert property (p_bp_cause) else $error("protect bits changed without command");
  a_lock: assert property (p_lock) else $error("locked bits changed");
endmodule

bind fsrp_status_reg fsrp_status_reg_monitor u_mon (.aclk, .aresetn, .s_axi_bvalid, .write_protect_n,
  .op_start, .op_erase, .op_done, .op_fail, .status_register_one);

//--- sim/test_flash_status_register_protect.sv
// Self-checking bench for the flash status register block
`timescale 1ns/1ps
module test_flash_status_register_protect;
  import fsrp_pkg::*;
  // Bench drive
  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  fsrp_addr_t  awaddr    = '0;
  logic        awvalid   = 1'b0;
  fsrp_data_t  wdata     = '0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  fsrp_addr_t  araddr    = '0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        wp_n      = 1'b1;
  logic        eng_fail  = 1'b0;
  logic [3:0]  eng_delay = 4'h1;
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid, op_start, op_erase, op_done, op_fail;
  logic [1:0]  bresp, rresp;
  fsrp_data_t  rdata;
  logic [7:0]  op_sector, status;
  // Bookkeeping; entry = code, flags(fail,pin,accepted), status in, config in, sector, status out
  int          bad_count = 0;
  int          samples_checked = 0;
  int          starts = 0;
  int          exp_starts = 0;
  logic [7:0]  last_sec = 8'h00;
  logic        last_er = 1'b0;
  logic [47:0] tab [19] = '{48'h0302_1C00_0000, 48'h0103_0000_0002, 48'h0303_9C00_009E, 48'h0402_0000_FF9E,
    48'h0300_0000_009E, 48'h0303_0800_000A, 48'h0301_0400_0006, 48'h0405_0000_FB46, 48'h0500_0000_FC46,
    48'h0505_0000_0066, 48'h0401_0000_0026, 48'h0301_0420_0026, 48'h0400_0000_0326, 48'h0401_0000_FF26,
    48'h0600_0000_0026, 48'h0301_0008_003E, 48'h0301_0008_0022, 48'h0201_0000_0020, 48'h0400_0000_1020};

  // Clock, 25 ns period
  initial forever #12.5 aclk = ~aclk;

  fsrp_status_reg u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .write_protect_n(wp_n), .op_start(op_start), .op_erase(op_erase), .op_sector(op_sector),
    .op_done(op_done), .op_fail(op_fail), .status_register_one(status));

  fsrp_engine_model u_eng (.aclk(aclk), .op_start(op_start), .fail_req(eng_fail), .delay(eng_delay),
    .op_done(op_done), .op_fail(op_fail));

  // Record every launch seen at the engine side
  always @(posedge aclk) begin
    if (op_start === 1'b1) begin
      starts   <= starts + 1;
      last_sec <= op_sector;
      last_er  <= op_erase;
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input fsrp_data_t got, input fsrp_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write cycle; address and data released as each is taken
  task automatic axw(input fsrp_addr_t a, input fsrp_data_t d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Wait for the answer; only the watchdog ends a wait that never comes
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'({bvalid, bresp}), 32'({1'b1, er}));
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read cycle with masked compare of the data
  task automatic rdc(input fsrp_addr_t a, input fsrp_data_t m, input fsrp_data_t e, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    // Data is taken at the edge where rvalid is first seen high
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(32'({rvalid, rresp}), 32'({1'b1, er}));
    chk(rdata & m, e);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    #(25 * 20000);
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [47:0] t;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(8'h00, 32'h0000_00FF, 32'h0000_0000, 2'h0);
    for (int i = 0; i < 19; i++) begin
      t = tab[i];
      wp_n      <= t[33];
      eng_fail  <= t[34];
      eng_delay <= 4'(1 + (i % 4) * 4);
      repeat (4) @(posedge aclk);
      axw(8'h08, {t[15:8], t[23:16], t[31:24], 5'h00, t[42:40]}, 2'h0);
      rdc(8'h00, 32'h0000_0001, 32'(t[32] && t[42:40] >= 3'h3), 2'h0);
      for (int n = 0; n < 60 && status[0] !== 1'b0; n++) @(posedge aclk);
      rdc(8'h0C, 32'h0000_0003, t[32] ? 32'h0000_0002 : 32'h0000_0001, 2'h0);
      rdc(8'h00, 32'h0000_00FF, 32'(t[7:0]), 2'h0);
      if (t[32] && t[42:40] >= 3'h4) begin
        exp_starts++;
        chk(32'(last_sec), 32'(t[15:8]));
        chk(32'(last_er), 32'(t[42:40] == 3'h5));
      end
      chk(32'(starts), 32'(exp_starts));
    end
    rdc(8'h04, 32'h0000_00FF, 32'h0000_0008, 2'h0);
    axw(8'h00, 32'h0000_00FF, 2'h0);
    rdc(8'h00, 32'h0000_00FF, 32'h0000_0020, 2'h0);
    axw(8'h10, 32'h0000_0001, 2'h2);
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2);
    // Reset in mid-run must clear the erase error left set above
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(8'h00, 32'h0000_00FF, 32'h0000_0000, 2'h0);
    give_verdict();
  end
endmodule
